// file: hdl/uamfb_top.sv
// Serial port enhancements: framing check, address recognition and baud clock selection.
//
// Overview of operation
// - In modes 1, 2 and 3 with frame checking on, an invalid stop bit sets the framing error flag.
// - The framing error flag stays set until software clears it or reset, valid frames never clear it.
// - With frame checking on, the receive done flag rises at the stop bit, not at the last data bit.
// - With multiprocessor mode on, receive done is raised only for a given or broadcast address match.
// - In mode 1 with address recognition, the stop bit is the ninth bit and must be valid with a match.
// - In mode 0 the multiprocessor enable bit has no effect.
// - The given address compares only bit positions where the mask register holds one.
// - The broadcast address is address OR mask, and only its one bits must match.
// - Reset clears the slave address and mask registers so any address is accepted.
// - Each direction takes the internal generator first, then timer two, then timer one.
// - The selectable baud sources apply to modes 1 and 3.
// - Transmit and receive run at the same time, each at its own rate.
// - The internal generator ticks on overflow of an 8-bit counter reloaded from the reload value.
// - The internal rate is 2^double times the clock over 2*2*6^(1-speed)*16*(256-reload).
// - The framing error flag shares bit 7 of the serial control register and shows only with checking on.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`default_nettype none

module uamfb_top
    import uamfb_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Timer overflow pulses
    input wire logic T1_OVF,
    input wire logic T2_OVF,
    // Serial line
    input wire logic RXD,
    output logic TXD,
    // Interrupt
    output logic IRQ
);

    // ***************************************************************
    // Registers
    // ***************************************************************
    uamfb_serial_control_reg_t serial_control_reg;
    logic framing_error_flag, receive_done_flag, transmit_done_flag, rx_ninth;
    logic [7:0] slave_address, slave_address_mask, rate_reload_value, rx_buf;
    logic rate_double, frame_check_enable;
    logic run_gen, tx_use_internal_gen, rx_use_internal_gen, speed_select;
    logic tx_use_timer_two, rx_use_timer_two;
    logic [2:0] irq_status, irq_mask;
    logic [7:0] read_idx;

    // ***************************************************************
    // Bus decode
    // ***************************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a == {2'b00, idx, 2'b00});
    endfunction : hit

    wire setup = PSEL && !PENABLE;
    wire wr = PSEL && PENABLE && PREADY && PWRITE;
    wire rd_done = PSEL && PENABLE && PREADY && !PWRITE;
    wire [7:0] wb = PWDATA[7:0];
    wire mapped = hit(PADDR, IDX_POWER_CTRL) || hit(PADDR, IDX_SERIAL_CTRL) || hit(PADDR, IDX_SERIAL_BUF)
        || hit(PADDR, IDX_RATE_RELOAD) || hit(PADDR, IDX_RATE_GEN_CTRL) || hit(PADDR, IDX_SLAVE_ADDRESS)
        || hit(PADDR, IDX_SLAVE_ADDRESS_MASK) || hit(PADDR, IDX_TIMER_TWO_CTRL) || hit(PADDR, IDX_IRQ_STATUS)
        || hit(PADDR, IDX_IRQ_MASK);
    wire wr_serial_control_reg = wr && hit(PADDR, IDX_SERIAL_CTRL);
    wire wr_sbuf = wr && hit(PADDR, IDX_SERIAL_BUF);
    wire bit7 = frame_check_enable ? framing_error_flag : serial_control_reg.mode_hi;
    wire [7:0] serial_control_reg_rd = {bit7, serial_control_reg.mode_lo, serial_control_reg.multiprocessor_enable, serial_control_reg.rx_enable, serial_control_reg.tx_ninth,
        rx_ninth, transmit_done_flag, receive_done_flag};
    wire [7:0] next_rd =
        hit(PADDR, IDX_POWER_CTRL) ? {rate_double, frame_check_enable, 6'h00} :
        hit(PADDR, IDX_SERIAL_CTRL) ? serial_control_reg_rd :
        hit(PADDR, IDX_SERIAL_BUF) ? rx_buf :
        hit(PADDR, IDX_RATE_RELOAD) ? rate_reload_value :
        hit(PADDR, IDX_RATE_GEN_CTRL) ? {3'h0, run_gen, tx_use_internal_gen, rx_use_internal_gen, speed_select, 1'b0} :
        hit(PADDR, IDX_SLAVE_ADDRESS) ? slave_address :
        hit(PADDR, IDX_SLAVE_ADDRESS_MASK) ? slave_address_mask :
        hit(PADDR, IDX_TIMER_TWO_CTRL) ? {2'h0, rx_use_timer_two, tx_use_timer_two, 4'h0} :
        hit(PADDR, IDX_IRQ_STATUS) ? {5'h00, irq_status} :
        hit(PADDR, IDX_IRQ_MASK) ? {5'h00, irq_mask} : 8'h00;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
            read_idx <= RST_BYTE;
        end else begin
            PREADY <= setup;
            if (setup) begin
                PRDATA <= {24'h00_0000, next_rd};
                PSLVERR <= !mapped;
                read_idx <= PADDR[9:2];
            end
        end
    end

    // ***************************************************************
    // Baud sources
    // ***************************************************************
    logic [4:0] presc;
    logic [7:0] brg_cnt;
    logic brg_tick, t1_half, m2_tick;
    logic [1:0] m2_cnt;
    wire [4:0] presc_max = speed_select ? (rate_double ? PRESC_FAST_X2 : PRESC_FAST)
        : (rate_double ? PRESC_SLOW_X2 : PRESC_SLOW);
    wire presc_hit = run_gen && (presc == presc_max);
    wire next_brg_tick = presc_hit && (brg_cnt == 8'hff);
    wire t1_tick = T1_OVF && (rate_double || t1_half);
    wire is_mode0 = !serial_control_reg.mode_hi && !serial_control_reg.mode_lo;
    wire is_mode1 = !serial_control_reg.mode_hi && serial_control_reg.mode_lo;
    wire is_mode2 = serial_control_reg.mode_hi && !serial_control_reg.mode_lo;
    wire tx_tick = is_mode2 ? m2_tick : tx_use_internal_gen ? brg_tick
        : tx_use_timer_two ? T2_OVF : t1_tick;
    wire rx_tick = is_mode2 ? m2_tick : rx_use_internal_gen ? brg_tick
        : rx_use_timer_two ? T2_OVF : t1_tick;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            presc <= 5'h00;
            brg_cnt <= RST_BYTE;
            brg_tick <= 1'b0;
            t1_half <= 1'b0;
            m2_cnt <= 2'h0;
            m2_tick <= 1'b0;
        end else begin
            presc <= (presc_hit || !run_gen) ? 5'h00 : presc + 5'h01;
            if (presc_hit) begin
                brg_cnt <= next_brg_tick ? rate_reload_value : brg_cnt + 8'h01;
            end
            brg_tick <= next_brg_tick;
            if (T1_OVF) begin
                t1_half <= !t1_half;
            end
            m2_cnt <= m2_cnt + 2'h1;
            m2_tick <= (m2_cnt == (rate_double ? MODE2_DIV >> 1 : MODE2_DIV)) || (rate_double && m2_cnt == MODE2_DIV);
        end
    end

    // ***************************************************************
    // Receive line synchroniser
    // ***************************************************************
    logic rx_s1, rx_s2, rx_s3, rx_line;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
            rx_line <= 1'b1;
        end else begin
            rx_s1 <= RXD;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3) begin
                rx_line <= rx_s3;
            end
        end
    end

    // ***************************************************************
    // Receiver
    // ***************************************************************
    function automatic logic addr_match(input logic [7:0] a, input logic [7:0] sa, input logic [7:0] sm);
        logic [7:0] bc;
        bc = sa | sm;
        addr_match = (((a ^ sa) & sm) == 8'h00) || (((a ^ bc) & bc) == 8'h00);
    endfunction : addr_match

    uamfb_state_t rx_state;
    logic [3:0] rx_cnt, rx_idx;
    logic [8:0] rx_sh;
    wire mp_eff = serial_control_reg.multiprocessor_enable && !is_mode0;
    wire stop_point = frame_check_enable || (is_mode1 && mp_eff);
    wire rx_sample = rx_tick && (rx_cnt == SAMPLE_END);
    wire [3:0] last_idx = is_mode1 ? BITS_MODE1 : BITS_NINE;
    wire rx_last = rx_idx == last_idx;
    logic [8:0] next_sh;
    always_comb begin
        next_sh = rx_sh;
        if (rx_state == UAMFB_DATA) begin
            next_sh[rx_idx] = rx_line;
        end
    end
    wire frm_ninth = is_mode1 ? rx_line : next_sh[8];
    wire rx_accept = !mp_eff
        || (frm_ninth && addr_match(next_sh[7:0], slave_address, slave_address_mask));
    wire rx_fire = rx_sample && ((rx_state == UAMFB_DATA && rx_last && !stop_point)
        || (rx_state == UAMFB_STOP && stop_point));
    wire fe_event = rx_sample && rx_state == UAMFB_STOP && frame_check_enable && !rx_line;
    wire rx_set = rx_fire && rx_accept;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_state <= UAMFB_IDLE;
            rx_cnt <= 4'h0;
            rx_idx <= 4'h0;
            rx_sh <= 9'h000;
        end else if (!serial_control_reg.rx_enable || is_mode0) begin
            rx_state <= UAMFB_IDLE;
        end else if (rx_tick) begin
            rx_cnt <= rx_cnt + 4'h1;
            case (rx_state)
                UAMFB_IDLE: begin
                    rx_cnt <= 4'h0;
                    rx_idx <= 4'h0;
                    if (!rx_line) begin
                        rx_state <= UAMFB_START;
                    end
                end
                UAMFB_START: begin
                    if (rx_cnt == SAMPLE_MID) begin
                        rx_cnt <= 4'h0;
                        rx_state <= rx_line ? UAMFB_IDLE : UAMFB_DATA;
                    end
                end
                UAMFB_DATA: begin
                    if (rx_sample) begin
                        rx_sh <= next_sh;
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_last) begin
                            rx_state <= UAMFB_STOP;
                        end
                    end
                end
                UAMFB_STOP: begin
                    if (rx_sample) begin
                        rx_state <= UAMFB_IDLE;
                    end
                end
                default: begin
                    rx_state <= UAMFB_IDLE;
                end
            endcase
        end
    end

    // ***************************************************************
    // Transmitter, runs beside the receiver on its own tick
    // ***************************************************************
    logic [10:0] tx_sh;
    logic [3:0] tx_cnt, tx_idx;
    logic tx_busy;
    wire [3:0] tx_stop = is_mode1 ? TX_STOP_MODE1 : TX_STOP_NINE;
    wire tx_bit_end = tx_busy && tx_tick && (tx_cnt == SAMPLE_END);
    wire tx_start = wr_sbuf && !tx_busy && !is_mode0;
    wire ti_event = tx_bit_end && (tx_idx + 4'h1 == tx_stop);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_sh <= 11'h7ff;
            tx_cnt <= 4'h0;
            tx_idx <= 4'h0;
            tx_busy <= 1'b0;
        end else if (tx_start) begin
            tx_sh <= {1'b1, is_mode1 | serial_control_reg.tx_ninth, wb, 1'b0};
            tx_cnt <= 4'h0;
            tx_idx <= 4'h0;
            tx_busy <= 1'b1;
        end else if (tx_busy && tx_tick) begin
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_bit_end) begin
                tx_idx <= tx_idx + 4'h1;
                if (tx_idx == tx_stop) begin
                    tx_busy <= 1'b0;
                end else begin
                    tx_sh <= {1'b1, tx_sh[10:1]};
                end
            end
        end
    end
    assign TXD = tx_sh[0];

    // ***************************************************************
    // Software registers and flags, hardware set wins over clear
    // ***************************************************************
    wire status_rd = rd_done && (read_idx == IDX_IRQ_STATUS);
    wire [2:0] events = {fe_event, ti_event, rx_set};
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            serial_control_reg <= '0;
            framing_error_flag <= 1'b0;
            receive_done_flag <= 1'b0;
            transmit_done_flag <= 1'b0;
            rx_ninth <= 1'b0;
            rx_buf <= RST_BYTE;
            slave_address <= RST_BYTE;
            slave_address_mask <= RST_BYTE;
            rate_reload_value <= RST_BYTE;
            {rate_double, frame_check_enable} <= 2'b00;
            {run_gen, tx_use_internal_gen, rx_use_internal_gen, speed_select} <= 4'h0;
            {tx_use_timer_two, rx_use_timer_two} <= 2'b00;
            irq_status <= RST_IRQ;
            irq_mask <= RST_IRQ;
            IRQ <= 1'b0;
        end else begin
            if (wr_serial_control_reg) begin
                if (frame_check_enable) begin
                    framing_error_flag <= wb[7];
                end else begin
                    serial_control_reg.mode_hi <= wb[7];
                end
                {serial_control_reg.mode_lo, serial_control_reg.multiprocessor_enable, serial_control_reg.rx_enable, serial_control_reg.tx_ninth} <= wb[6:3];
                rx_ninth <= wb[2];
                transmit_done_flag <= wb[1];
                receive_done_flag <= wb[0];
            end
            if (wr && hit(PADDR, IDX_POWER_CTRL)) begin
                rate_double <= wb[POS_RATE_DOUBLE];
                frame_check_enable <= wb[POS_FRAME_CHECK];
            end
            if (wr && hit(PADDR, IDX_RATE_RELOAD)) begin
                rate_reload_value <= wb;
            end
            if (wr && hit(PADDR, IDX_RATE_GEN_CTRL)) begin
                run_gen <= wb[POS_RUN_GEN];
                tx_use_internal_gen <= wb[POS_TX_INTERNAL];
                rx_use_internal_gen <= wb[POS_RX_INTERNAL];
                speed_select <= wb[POS_SPEED_SELECT];
            end
            if (wr && hit(PADDR, IDX_TIMER_TWO_CTRL)) begin
                rx_use_timer_two <= wb[POS_RX_TIMER_TWO];
                tx_use_timer_two <= wb[POS_TX_TIMER_TWO];
            end
            if (wr && hit(PADDR, IDX_SLAVE_ADDRESS)) begin
                slave_address <= wb;
            end
            if (wr && hit(PADDR, IDX_SLAVE_ADDRESS_MASK)) begin
                slave_address_mask <= wb;
            end
            if (wr && hit(PADDR, IDX_IRQ_MASK)) begin
                irq_mask <= wb[2:0];
            end
            if (fe_event) begin
                framing_error_flag <= 1'b1;
            end
            if (rx_set) begin
                receive_done_flag <= 1'b1;
                rx_buf <= next_sh[7:0];
                rx_ninth <= frm_ninth;
            end
            if (ti_event) begin
                transmit_done_flag <= 1'b1;
            end
            irq_status <= (irq_status & ~(status_rd ? PRDATA[2:0] : 3'h0)) | events;
            IRQ <= |(irq_status & irq_mask);
        end
    end

    // ***************************************************************
    // Checks
    // ***************************************************************
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_fe_set: assert property (fe_event |=> framing_error_flag) else $error("framing error not flagged");
    a_fe_sticky: assert property (framing_error_flag && !wr_serial_control_reg |=> framing_error_flag)
        else $error("framing error flag dropped");
    a_rx_done_point: assert property ($rose(receive_done_flag) && frame_check_enable && !$past(wr_serial_control_reg)
        |-> $past(rx_state) == UAMFB_STOP) else $error("receive done not at stop bit");
    a_rx_match_only: assert property ($rose(receive_done_flag) && !$past(wr_serial_control_reg)
        |-> $past(!mp_eff || addr_match(next_sh[7:0], slave_address, slave_address_mask)))
        else $error("receive done without address match");
    a_mode1_stop: assert property (rx_set && is_mode1 && mp_eff |-> rx_line)
        else $error("mode 1 match without stop");
    a_mode0_mp: assert property (is_mode0 |-> !mp_eff) else $error("multiprocessor active in mode 0");
    a_nine_addr: assert property (rx_set && mp_eff && !is_mode1 |-> next_sh[8])
        else $error("data frame taken");
    a_tx_source: assert property (!is_mode2 && tx_use_internal_gen && tx_busy && !brg_tick |=> $stable(tx_cnt))
        else $error("transmit source priority wrong");
    a_brg_reload: assert property (next_brg_tick |=> brg_cnt == $past(rate_reload_value))
        else $error("generator not reloaded");
    a_fe_visible: assert property (setup && hit(PADDR, IDX_SERIAL_CTRL) && !frame_check_enable
        |=> PRDATA[7] == $past(serial_control_reg.mode_hi)) else $error("bit 7 shows wrong source");
    a_irq_level: assert property (|(irq_status & irq_mask) |=> IRQ) else $error("interrupt not raised");

endmodule : uamfb_top

`default_nettype wire

// file: hdl/uamfb_pkg.sv
// Package with register map, field positions, reset values and types of the serial port enhancement block.
package uamfb_pkg;

    // ***************************************************************
    // Register indices, byte address is four times the index
    // ***************************************************************
    localparam logic [7:0] IDX_POWER_CTRL = 8'h87;
    localparam logic [7:0] IDX_SERIAL_CTRL = 8'h98;
    localparam logic [7:0] IDX_SERIAL_BUF = 8'h99;
    localparam logic [7:0] IDX_RATE_RELOAD = 8'h9a;
    localparam logic [7:0] IDX_RATE_GEN_CTRL = 8'h9b;
    localparam logic [7:0] IDX_SLAVE_ADDRESS = 8'ha9;
    localparam logic [7:0] IDX_SLAVE_ADDRESS_MASK = 8'hb9;
    localparam logic [7:0] IDX_TIMER_TWO_CTRL = 8'hc8;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hf0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hf1;
    localparam int ADDR_W = 12;

    // ***************************************************************
    // Field positions
    // ***************************************************************
    localparam int POS_RATE_DOUBLE = 7;
    localparam int POS_FRAME_CHECK = 6;
    localparam int POS_RUN_GEN = 4;
    localparam int POS_TX_INTERNAL = 3;
    localparam int POS_RX_INTERNAL = 2;
    localparam int POS_SPEED_SELECT = 1;
    localparam int POS_RX_TIMER_TWO = 5;
    localparam int POS_TX_TIMER_TWO = 4;
    localparam int POS_IRQ_RX = 0;
    localparam int POS_IRQ_TX = 1;
    localparam int POS_IRQ_FE = 2;

    // ***************************************************************
    // Reset values and counts
    // ***************************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_IRQ = 3'h0;
    localparam logic [4:0] PRESC_SLOW = 5'h17;
    localparam logic [4:0] PRESC_SLOW_X2 = 5'h0b;
    localparam logic [4:0] PRESC_FAST = 5'h03;
    localparam logic [4:0] PRESC_FAST_X2 = 5'h01;
    localparam logic [1:0] MODE2_DIV = 2'h3;
    localparam logic [3:0] SAMPLE_MID = 4'h7;
    localparam logic [3:0] SAMPLE_END = 4'hf;
    localparam logic [3:0] BITS_MODE1 = 4'h7;
    localparam logic [3:0] BITS_NINE = 4'h8;
    localparam logic [3:0] TX_STOP_MODE1 = 4'h9;
    localparam logic [3:0] TX_STOP_NINE = 4'ha;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef enum logic [1:0] {
        UAMFB_IDLE = 2'b00,
        UAMFB_START = 2'b01,
        UAMFB_DATA = 2'b11,
        UAMFB_STOP = 2'b10
    } uamfb_state_t;

    typedef struct packed {
        logic mode_hi;
        logic mode_lo;
        logic multiprocessor_enable;
        logic rx_enable;
        logic tx_ninth;
    } uamfb_serial_control_reg_t;

endpackage : uamfb_pkg

// file: test/uamfb_remote.sv
// Remote processor model that sends frames on the shared serial line.
`timescale 1ns/10ps
`default_nettype none
module uamfb_remote #(
    parameter int BIT_CLKS = 32
) (
    // Clock and serial line
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    initial rxd = 1'b1;
    // Sends start bit, eight data bits lsb first, ninth bit and stop bit, then idles high.
    task automatic send_frame(input logic [7:0] d, input logic nb, input logic stp);
        logic [10:0] f;
        f = {stp, nb, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            rxd <= f[i];
            repeat (BIT_CLKS - 1) @(posedge clk);
        end
        @(posedge clk);
        rxd <= 1'b1;
    endtask : send_frame
    // Receives one frame from the device, sampling each bit after the start bit in its middle, stop bit last.
    task automatic recv_frame(input int bc, output logic [9:0] f);
        @(negedge txd);
        repeat (bc / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            repeat (bc) @(posedge clk);
            f[i] = txd;
        end
    endtask : recv_frame
endmodule : uamfb_remote
`default_nettype wire

// file: test/tb_top.sv
// Self-checking testbench of the serial port enhancement block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import uamfb_pkg::*;
    logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, T1_OVF = 1'b0, T2_OVF = 1'b0;
    logic [ADDR_W-1:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA;
    logic PREADY, PSLVERR, RXD, TXD, IRQ;
    logic [32:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [7:0] rnd;
    logic [9:0] tx_f;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    logic [8:0] tbl[4] = '{9'h1f0, 9'h0f3, 9'h1fb, 9'h0f2};
    uamfb_top i_uamfb_top (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .T1_OVF(T1_OVF), .T2_OVF(T2_OVF), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));
    uamfb_remote #(.BIT_CLKS(32)) i_uamfb_remote (.clk(CLK), .txd(TXD), .rxd(RXD));
    initial begin
        forever #50 CLK = ~CLK;
    end
    // Timer two overflows every second cycle, giving 32 clocks per bit.
    always @(posedge CLK) begin
        T2_OVF <= ~T2_OVF;
        T1_OVF <= (cyc % 3 == 0);
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Read results are compared against the oldest note when the access completes.
    always @(posedge CLK) begin
        if (PSEL && PENABLE && PREADY && !PWRITE && exp_q.size() > 0) begin
            chk({PSLVERR, PRDATA & msk_q[0]}, exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [32:0] e,
        input logic [31:0] m);
        if (!w) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= {2'b00, idx, 2'b00};
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h0, d}, '0, '0);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [32:0] e, input logic [31:0] m);
        apb(1'b0, idx, '0, e, m);
    endtask : rd
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    initial begin
        rnd = $urandom(32'hebe0);
        repeat (8) @(posedge CLK);
        RST_N <= 1'b1;
        rd(IDX_SLAVE_ADDRESS, 33'h0, 32'hff);
        rd(IDX_SLAVE_ADDRESS_MASK, 33'h0, 32'hff);
        rd(8'h00, 33'h100000000, 32'h0);
        wr(IDX_SERIAL_CTRL, 8'hf0);
        wr(IDX_POWER_CTRL, 8'h40);
        wr(IDX_TIMER_TWO_CTRL, 8'h30);
        wr(IDX_RATE_RELOAD, 8'hff);
        wr(IDX_RATE_GEN_CTRL, 8'h1a);
        rd(IDX_TIMER_TWO_CTRL, 33'h30, 32'hff);
        // Reset addresses accept any address frame.
        rnd = $urandom;
        i_uamfb_remote.send_frame(rnd, 1'b1, 1'b1);
        rd(IDX_IRQ_STATUS, 33'h1, 32'h1);
        rd(IDX_SERIAL_BUF, {25'h0, rnd}, 32'hff);
        wr(IDX_SLAVE_ADDRESS, 8'hf1);
        wr(IDX_SLAVE_ADDRESS_MASK, 8'hfa);
        for (int i = 0; i < 4; i++) begin
            i_uamfb_remote.send_frame(tbl[i][7:0], 1'b1, 1'b1);
            rd(IDX_IRQ_STATUS, {32'h0, tbl[i][8]}, 32'h1);
        end
        // Data frame with ninth bit clear is ignored even when its value matches.
        i_uamfb_remote.send_frame(8'hf0, 1'b0, 1'b1);
        rd(IDX_IRQ_STATUS, 33'h0, 32'h1);
        wr(IDX_IRQ_MASK, 8'h04);
        i_uamfb_remote.send_frame(8'hf0, 1'b1, 1'b0);
        rd(IDX_SERIAL_CTRL, 33'h80, 32'h80);
        repeat (3) @(posedge CLK);
        chk({32'h0, IRQ}, 33'h1);
        i_uamfb_remote.send_frame(8'hf0, 1'b1, 1'b1);
        rd(IDX_SERIAL_CTRL, 33'h80, 32'h80);
        rd(IDX_IRQ_STATUS, 33'h4, 32'h4);
        repeat (3) @(posedge CLK);
        chk({32'h0, IRQ}, 33'h0);
        wr(IDX_SERIAL_CTRL, 8'h70);
        rd(IDX_SERIAL_CTRL, 33'h0, 32'h80);
        // Transmit on the internal generator, 64 clocks per bit, while a frame arrives on timer two.
        rnd = $urandom;
        fork
            i_uamfb_remote.recv_frame(64, tx_f);
            wr(IDX_SERIAL_BUF, rnd);
            i_uamfb_remote.send_frame(8'hfb, 1'b1, 1'b1);
        join
        chk({23'h0, tx_f}, {23'h0, 2'b10, rnd});
        rd(IDX_IRQ_STATUS, 33'h3, 32'h7);
        repeat (4) @(posedge CLK);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
